//--- meter_spi_regs.svh
`ifndef METER_SPI_REGS_SVH
`define METER_SPI_REGS_SVH
`define MSPI_ID_READ      8'h58
`define MSPI_ID_WRITE     8'ha8
`define MSPI_FRAME_BITS   6'd48
`define MSPI_ONES_BYTES   3'd6
`define MSPI_MAX_KHZ      900
`define MSPI_SYS_MHZ      40
`define MSPI_HALF_CYC     ((`MSPI_SYS_MHZ * 1000 + 2 * `MSPI_MAX_KHZ - 1) / (2 * `MSPI_MAX_KHZ))
`endif

//--- meter_spi_pkg.sv
package meter_spi_pkg;
  typedef enum logic [1:0] {HIdle, HRun, HDone} host_state_e;
  typedef logic [7:0] byte_t;
  function automatic byte_t frameSum(input byte_t id, input byte_t addr,
                                     input logic [23:0] data);
    logic [7:0] s;
    s = id + addr + data[23:16] + data[15:8] + data[7:0];
    return ~s;
  endfunction : frameSum
endpackage : meter_spi_pkg

//--- meter_spi_if.sv
`timescale 1ns/10ps
`default_nettype none
interface meter_spi_if;
  logic sclk;
  logic sdi;
  logic sdoOut;
  logic sdoOe;
  logic portSel;
  modport device (input sclk, input sdi, input portSel,
                  output sdoOut, output sdoOe);
  modport host (output sclk, output sdi, output portSel,
                input sdoOut, input sdoOe);
endinterface : meter_spi_if
`default_nettype wire

//--- meter_spi_device.sv
`timescale 1ns/10ps
`default_nettype none
`include "meter_spi_regs.svh"
// Notes on behaviour
// - select pin gates only this port's sdo drive versus uart; capture and writes ignore it
// - half-duplex slave, clock at most 900 khz
// - bytes are eight bits, msb first
// - master uses mode 1, clock idles low
// - capture on falling, launch on rising
// - first byte 0x58 reads, 0xa8 writes
// - second byte is the register address
// - a frame is exactly 48 clocks
// - after a frame, wait for new id
// - data is three bytes, high first
// - master appends inverted sum on writes
// - device appends inverted sum on reads
// - master sets data before falling edge
// - after read address, shift register data out
// - output stable while clock is high
// - master samples by next falling edge
// - output released on last falling edge
// - six 0xff bytes reset the port
module meter_spi_device (
  meter_spi_if.device link,
  input  wire logic        clk,
  input  wire logic        rstn,
  output logic             wrStb,
  output logic [7:0]       wrAddr,
  output logic [23:0]      wrData,
  output logic [7:0]       rdAddr,
  input  wire logic [23:0] rdData,
  output logic             spiActive
);
  // falling-edge (capture) domain state
  typedef struct packed {
    logic [5:0]  bitCnt;
    logic [7:0]  shiftIn;
    logic [7:0]  idByte;
    logic [7:0]  addr;
    logic [23:0] data;
    logic [2:0]  onesCnt;
    logic [23:0] wrHold;
    logic [7:0]  wrAddrHold;
    logic        wrTgl;
    logic        oeOff;
  } fall_s;
  fall_s f_r, f_nxt;
  // rising-edge (launch) domain state
  typedef struct packed {
    logic [23:0] rdSnap;
    logic [7:0]  txSh;
    logic        txBit;
    logic        oe;
    logic [1:0]  selSync;
  } rise_s;

  // system clock domain state
  typedef struct packed {
    logic [2:0]  tglSync;
    logic        wrStb;
    logic [23:0] wrData;
    logic [7:0]  wrAddr;
  } sys_s;
  rise_s       r_r, r_nxt;
  sys_s        s_r, s_nxt;
  logic [7:0]  rxByte;
  logic        byteDone;
  logic [7:0]  wrSum;
  logic        wrOk;
  logic [7:0]  rdSum;

  // byte to launch at each byte boundary of the read data phase
  function automatic logic [7:0] txByteAt(input logic [23:0] snap,
                                          input logic [7:0]  sum,
                                          input logic [5:0]  cnt);
    logic [7:0] b;
    b = 8'h00;
    if (cnt == 6'd16) begin
      b = snap[23:16];
    end else if (cnt == 6'd24) begin
      b = snap[15:8];
    end else if (cnt == 6'd32) begin
      b = snap[7:0];
    end else if (cnt == 6'd40) begin
      b = sum;
    end
    return b;
  endfunction : txByteAt

  assign rxByte   = {f_r.shiftIn[6:0], link.sdi};
  assign byteDone = (f_r.bitCnt[2:0] == 3'd7);

  // a write lands only with the write id and a matching checksum
  assign wrSum = meter_spi_pkg::frameSum(`MSPI_ID_WRITE, f_r.addr,
                                         f_r.data);
  assign wrOk  = (f_r.idByte == `MSPI_ID_WRITE) &&
                 (rxByte == wrSum);

  // capture side: one bit per falling edge, frames counted from reset
  always_comb begin
    f_nxt = f_r;
    f_nxt.shiftIn = rxByte;
    f_nxt.bitCnt  = f_r.bitCnt + 6'd1;
    f_nxt.oeOff   = 1'b0;
    if (byteDone) begin
      if (f_r.bitCnt[5:3] == 3'd0) begin
        f_nxt.idByte = rxByte;
      end else if (f_r.bitCnt[5:3] == 3'd1) begin
        f_nxt.addr = rxByte;
      end else if (f_r.bitCnt[5:3] < 3'd5) begin
        f_nxt.data = {f_r.data[15:0], rxByte};
      end
      if (rxByte == 8'hff) begin
        f_nxt.onesCnt = f_r.onesCnt + 3'd1;
      end else begin
        f_nxt.onesCnt = 3'd0;
      end
    end
    if (f_r.bitCnt == `MSPI_FRAME_BITS - 6'd1) begin
      f_nxt.bitCnt = 6'd0;
      f_nxt.oeOff  = 1'b1;
      if (wrOk) begin
        f_nxt.wrHold     = f_r.data;
        f_nxt.wrAddrHold = f_r.addr;
        f_nxt.wrTgl      = ~f_r.wrTgl;
      end
    end
    // six bytes of ones snap the port back to waiting for an id
    if (byteDone && rxByte == 8'hff &&
        f_r.onesCnt == `MSPI_ONES_BYTES - 3'd1) begin
      f_nxt.bitCnt  = 6'd0;
      f_nxt.onesCnt = 3'd0;
      f_nxt.idByte  = 8'h00;
      f_nxt.oeOff   = 1'b1;
    end
  end

  always_ff @(negedge link.sclk or negedge rstn) begin
    if (!rstn) f_r <= '0;
    else       f_r <= f_nxt;
  end

  // launch side: output changes only on rising edges, so it holds while high
  assign rdSum = meter_spi_pkg::frameSum(`MSPI_ID_READ, f_r.addr,
                                         r_r.rdSnap);

  always_comb begin
    logic [7:0] firstByte;
    logic [7:0] nextByte;
    firstByte = txByteAt(rdData, rdSum, 6'd16);
    nextByte  = txByteAt(r_r.rdSnap, rdSum, f_r.bitCnt);
    r_nxt = r_r;
    // the mux select rides the link clock only while frames run
    r_nxt.selSync = {r_r.selSync[0], link.portSel};
    if (f_r.oeOff || !r_r.selSync[1]) begin
      r_nxt.oe = 1'b0;
    end else if (f_r.idByte == `MSPI_ID_READ && f_r.bitCnt == 6'd16) begin
      r_nxt.rdSnap = rdData;
      r_nxt.txBit  = firstByte[7];
      r_nxt.txSh   = {firstByte[6:0], 1'b0};
      r_nxt.oe     = 1'b1;
    // byte boundaries reload from the snapshot or its sum, else keep shifting
    end else if (r_r.oe && f_r.bitCnt != 6'd0) begin
      if (f_r.bitCnt[2:0] == 3'd0) begin
        r_nxt.txBit = nextByte[7];
        r_nxt.txSh  = {nextByte[6:0], 1'b0};
      end else begin
        r_nxt.txBit = r_r.txSh[7];
        r_nxt.txSh  = {r_r.txSh[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge link.sclk or negedge rstn) begin
    if (!rstn) r_r <= '0;
    else       r_r <= r_nxt;
  end

  // write event crosses to clk by toggle, data held stable meanwhile
  always_comb begin
    logic wrEvent;
    wrEvent = s_r.tglSync[2] ^ s_r.tglSync[1];
    s_nxt = s_r;
    s_nxt.tglSync = {s_r.tglSync[1:0], f_r.wrTgl};
    s_nxt.wrStb   = wrEvent;
    if (wrEvent) begin
      s_nxt.wrData = f_r.wrHold;
      s_nxt.wrAddr = f_r.wrAddrHold;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) s_r <= '0;
    else       s_r <= s_nxt;
  end

  // release drops with the last falling edge, though the clock then stops
  assign link.sdoOut = r_r.txBit;
  assign link.sdoOe  = r_r.oe & ~f_r.oeOff;
  assign rdAddr      = f_r.addr;
  assign spiActive   = f_r.bitCnt != 6'd0;
  assign wrStb       = s_r.wrStb;
  assign wrData      = s_r.wrData;
  assign wrAddr      = s_r.wrAddr;
endmodule : meter_spi_device
`default_nettype wire

//--- meter_spi_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "meter_spi_regs.svh"
module meter_spi_host (
  meter_spi_if.host   link,
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        useSpi,
  input  wire logic        reqValid,
  input  wire logic        reqWrite,
  input  wire logic        reqReset,
  input  wire logic [7:0]  reqAddr,
  input  wire logic [23:0] reqData,
  output logic             reqReady,
  output logic             rspValid,
  output logic [23:0]      rspData,
  output logic             rspSumOk
);
  typedef struct packed {
    meter_spi_pkg::host_state_e st;
    logic [5:0]  half;
    logic [5:0]  bitCnt;
    logic [47:0] txSh;
    logic [31:0] rxSh;
    logic [7:0]  addr;
    logic        rd;
    logic        sclk;
    logic        sdi;
    logic        sel;
    logic        rspValid;
    logic [23:0] rspData;
    logic        sumOk;
    logic [1:0]  sdoSync;
  } host_s;
  host_s h_r, h_nxt;
  logic [7:0] sumW;

  always_comb begin
    h_nxt = h_r;
    h_nxt.sel      = useSpi;
    h_nxt.rspValid = 1'b0;
    h_nxt.sdoSync  = {h_r.sdoSync[0], link.sdoOut};
    sumW = meter_spi_pkg::frameSum(`MSPI_ID_WRITE, reqAddr, reqData);
    case (h_r.st)
      meter_spi_pkg::HIdle: begin
        h_nxt.sclk = 1'b0;
        if (reqValid) begin
          h_nxt.st = meter_spi_pkg::HRun;
          h_nxt.bitCnt = 6'd0;
          h_nxt.half = 6'd0;
          h_nxt.addr = reqAddr;
          h_nxt.rd = !reqWrite && !reqReset;
          if (reqReset) h_nxt.txSh = {48{1'b1}};
          else if (reqWrite)
            h_nxt.txSh = {`MSPI_ID_WRITE, reqAddr, reqData, sumW};
          else h_nxt.txSh = {`MSPI_ID_READ, reqAddr, 32'h00000000};
        end
      end
      meter_spi_pkg::HRun: begin
        h_nxt.half = h_r.half + 6'd1;
        if (h_r.half == 6'(`MSPI_HALF_CYC - 1)) begin
          h_nxt.half = 6'd0;
          h_nxt.sclk = ~h_r.sclk;
          if (!h_r.sclk) begin
            h_nxt.sdi  = h_r.txSh[47];
            h_nxt.txSh = {h_r.txSh[46:0], 1'b0};
          end else begin
            h_nxt.rxSh = {h_r.rxSh[30:0], h_r.sdoSync[1]};
            h_nxt.bitCnt = h_r.bitCnt + 6'd1;
            if (h_r.bitCnt == `MSPI_FRAME_BITS - 6'd1)
              h_nxt.st = meter_spi_pkg::HDone;
          end
        end
      end
      default: begin
        h_nxt.st = meter_spi_pkg::HIdle;
        h_nxt.rspValid = h_r.rd;
        h_nxt.rspData  = h_r.rxSh[31:8];
        h_nxt.sumOk = h_r.rxSh[7:0] ==
          meter_spi_pkg::frameSum(`MSPI_ID_READ, h_r.addr, h_r.rxSh[31:8]);
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) h_r <= '0;
    else       h_r <= h_nxt;
  end

  assign link.sclk    = h_r.sclk;
  assign link.sdi     = h_r.sdi;
  assign link.portSel = h_r.sel;
  assign reqReady     = h_r.st == meter_spi_pkg::HIdle;
  assign rspValid     = h_r.rspValid;
  assign rspData      = h_r.rspData;
  assign rspSumOk     = h_r.sumOk;
endmodule : meter_spi_host
`default_nettype wire

//--- meter_spi_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module meter_spi_monitor (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdoOut,
  input wire logic sdoOe,
  input wire logic portSel
);
  logic [5:0] bitCnt;
  logic [7:0] lowCnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // falling edges within the current frame
  always_ff @(negedge sclk or negedge rstn) begin
    if (!rstn) begin
      bitCnt <= 6'h00;
    end else begin
      bitCnt <= (bitCnt == 6'h2f) ? 6'h00 : bitCnt + 6'h01;
    end
  end
  // clk cycles the link clock has been low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lowCnt <= 8'h00;
    end else begin
      lowCnt <= sclk ? 8'h00 : (&lowCnt ? lowCnt : lowCnt + 8'h01);
    end
  end
  chk_high_time: assert property ($rose(sclk) |-> ##[22:24] $fell(sclk))
    else $error("sclk high time");
  chk_low_time: assert property ($fell(sclk) |-> !sclk [*8])
    else $error("sclk low time");
  chk_sdo_stable: assert property (sclk && $past(sclk) |-> $stable(sdoOut))
    else $error("sdo moved while sclk high");
  chk_sdi_stable: assert property ((sclk && $past(sclk)) || $fell(sclk) |-> $stable(sdi))
    else $error("sdi moved near capture");
  chk_oe_start: assert property ($rose(sdoOe) |-> bitCnt == 6'h10)
    else $error("sdo drive starts off count");
  chk_oe_release: assert property ($fell(sdoOe) |-> bitCnt == 6'h00)
    else $error("sdo release off count");
  chk_oe_sel: assert property (sdoOe |-> portSel)
    else $error("sdo driven while deselected");
  chk_frame_gap: assert property (lowCnt > 8'h30 |-> bitCnt == 6'h00)
    else $error("idle gap inside frame");
  cover property ($rose(sdoOe));
  cover property ($fell(sdoOe));
  cover property (lowCnt == 8'h40 && bitCnt == 6'h00);
endmodule : meter_spi_monitor
`default_nettype wire

//--- metering_spi_register_port_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin total_checks++; \
  if ((s) !== (e)) begin err_total++; \
  $display("Error %s exp %h got %h", nm, e, s); end end
module metering_spi_register_port_tb;
  logic        clk, rstn, useSpi, reqValid, reqWrite, reqReset;
  logic        reqReady, rspValid, rspSumOk, wrStb, allOnes, spiActive;
  logic [7:0]  reqAddr, wrAddr, rdAddr;
  logic [23:0] reqData, rspData, wrData, rdData;
  logic [47:0] sdiSh, sdoSh;
  int          err_total, total_checks;
  meter_spi_if link();
  meter_spi_host meter_spi_host_inst (.link(link), .clk(clk), .rstn(rstn),
    .useSpi(useSpi), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqReset(reqReset), .reqAddr(reqAddr), .reqData(reqData),
    .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
    .rspSumOk(rspSumOk));
  meter_spi_device meter_spi_device_inst (.link(link), .clk(clk),
    .rstn(rstn), .wrStb(wrStb), .wrAddr(wrAddr), .wrData(wrData),
    .rdAddr(rdAddr), .rdData(rdData), .spiActive(spiActive));
  meter_spi_monitor meter_spi_monitor_inst (.clk(clk), .rstn(rstn),
    .sclk(link.sclk), .sdi(link.sdi), .sdoOut(link.sdoOut),
    .sdoOe(link.sdoOe), .portSel(link.portSel));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // wire bits as captured on falling edges
  always @(negedge link.sclk) begin
    sdiSh <= {sdiSh[46:0], link.sdi};
    sdoSh <= {sdoSh[46:0], link.sdoOut};
    allOnes <= ({sdiSh[46:0], link.sdi} === {48{1'b1}});
  end
  function automatic logic [7:0] ckSum(input logic [7:0] id, a,
                                       input logic [23:0] d);
    logic [7:0] s;
    s = id + a + d[23:16] + d[15:8] + d[7:0];
    return ~s;
  endfunction : ckSum
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic waitHi(ref logic s);
    for (int n = 0; n < 5000; n++) begin
      if (s === 1'b1) return;
      @(posedge clk);
      #1;
    end
    err_total++;
    $display("Error wait exp 1 got timeout");
    tally_and_finish();
  endtask : waitHi
  task automatic issue(input logic w, r, input logic [7:0] a,
                       input logic [23:0] d);
    @(posedge clk);
    #1;
    {reqValid, reqWrite, reqReset, reqAddr, reqData} = {1'b1, w, r, a, d};
    waitHi(reqReady);
    @(posedge clk);
    #1;
    reqValid = 1'b0;
  endtask : issue
  task automatic t_select;
    #1;
    useSpi = 1'b0;
    repeat (4) @(posedge clk);
    `CHK("portSel", 1'b0, link.portSel)
    #1;
    useSpi = 1'b1;
    repeat (4) @(posedge clk);
    `CHK("portSel", 1'b1, link.portSel)
    $display("select test done");
  endtask : t_select
  task automatic t_write(input logic [7:0] a, input logic [23:0] d);
    issue(1'b1, 1'b0, a, d);
    waitHi(wrStb);
    `CHK("wrAddr", a, wrAddr)
    `CHK("wrData", d, wrData)
    `CHK("sdi", {8'ha8, a, d, ckSum(8'ha8, a, d)}, sdiSh)
    `CHK("sdoOe", 1'b0, link.sdoOe)
    @(posedge clk);
    #1;
    `CHK("wrStb", 1'b0, wrStb)
    $display("write test done");
  endtask : t_write
  task automatic t_read(input logic [7:0] a, input logic [23:0] d);
    @(posedge clk);
    #1;
    rdData = d;
    issue(1'b0, 1'b0, a, 24'h000000);
    waitHi(rspValid);
    `CHK("rspData", d, rspData)
    `CHK("rspSumOk", 1'b1, rspSumOk)
    `CHK("rdAddr", a, rdAddr)
    `CHK("sdo", {d, ckSum(8'h58, a, d)}, sdoSh[31:0])
    `CHK("sdi", {8'h58, a}, sdiSh[47:32])
    `CHK("sdoOe", 1'b0, link.sdoOe)
    `CHK("spiActive", 1'b0, spiActive)
    $display("read test done");
  endtask : t_read
  task automatic t_reset;
    issue(1'b0, 1'b1, 8'h00, 24'h000000);
    waitHi(allOnes);
    `CHK("wrStb", 1'b0, wrStb)
    t_write(8'h01, 24'h5a5a5a);
    $display("soft reset test done");
  endtask : t_reset
  initial begin
    {rstn, useSpi, reqValid, reqWrite, reqReset} = 5'h08;
    {reqAddr, reqData, rdData} = 56'h00000000000000;
    repeat (20) @(posedge clk);
    #1;
    rstn = 1'b1;
    t_select();
    t_write(8'h1b, 24'h00a5c3);
    t_read(8'h0e, 24'h0000ff);
    t_read(8'h3c, 24'hffffff);
    t_reset();
    tally_and_finish();
  end
endmodule : metering_spi_register_port_tb
`default_nettype wire
